/* verilog/lnbc_pkg.sv */
// lnbc_pkg: shared constants and types for the dual supply control block
package lnbc_pkg;
  // clock and tone timing
  localparam int CLK_HZ          = 20000000;
  localparam int TONE_HZ         = 22000;
  localparam int CONV_MULT       = 20;
  localparam int CONV_HALF_CYC   = CLK_HZ / (TONE_HZ * CONV_MULT * 2);
  localparam int TONE_HALF_TICKS = CONV_MULT;
  localparam logic [4:0] CONV_HALF_LAST = 5'(CONV_HALF_CYC - 1);
  localparam logic [4:0] TONE_HALF_LAST = 5'(TONE_HALF_TICKS - 1);

  // serial slave address: upper five bits fixed, low two from straps
  localparam logic [4:0] SLAVE_ADDR_BASE = 5'h04;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

  // register pointers
  localparam logic [1:0] REG_CTL_A  = 2'h0;
  localparam logic [1:0] REG_CTL_B  = 2'h1;
  localparam logic [1:0] REG_STAT_A = 2'h2;
  localparam logic [1:0] REG_STAT_B = 2'h3;

  // control register fields, same layout for both channels
  localparam int CB_EN         = 0;
  localparam int CB_LOW_STEP   = 1;
  localparam int CB_HIGH_STEP  = 2;
  localparam int CB_PIN_DIS    = 3;
  localparam int CB_TONE_CONT  = 4;
  localparam int CB_PASSTHRU   = 5;
  localparam int CB_THRESH     = 6;
  localparam logic [7:0] CTL_RST = 8'h00;

  // status register fields, same layout for both channels
  localparam int SB_OVERCUR  = 0;
  localparam int SB_BACKCUR  = 1;
  localparam int SB_OVERTEMP = 2;
  localparam int SB_ALL_OFF  = 3;
  localparam int SB_TONE_DET = 4;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b011,
    I_WDAT = 3'b010,
    I_WACK = 3'b110,
    I_RDAT = 3'b111,
    I_RACK = 3'b101
  } lnbc_i2c_st_t;
endpackage

/* verilog/lnbc_sync.sv */
// lnbc_sync: two flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module lnbc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lnbc_sync_t;

  lnbc_sync_t r_q;
  lnbc_sync_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule // lnbc_sync

/* verilog/lnbc_tone_osc.sv */
// lnbc_tone_osc: shared oscillator, converter clock at twenty times the tone
`timescale 1ns/1ps
module lnbc_tone_osc (
  input  wire logic mclk,
  input  wire logic rst_b,
  output logic      conv_clk,
  output logic      tone
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       conv;
    logic [4:0] tick;
    logic       tone;
  } lnbc_osc_t;

  lnbc_osc_t o_q;
  lnbc_osc_t o_d;

  always_comb begin
    o_d = o_q;
    if (o_q.cnt == lnbc_pkg::CONV_HALF_LAST) begin
      o_d.cnt  = 5'h00;
      o_d.conv = !o_q.conv;
      // tone toggles once per twenty converter half periods
      if (o_q.tick == lnbc_pkg::TONE_HALF_LAST) begin
        o_d.tick = 5'h00;
        o_d.tone = !o_q.tone;
      end else begin
        o_d.tick = o_q.tick + 5'h01;
      end
    end else begin
      o_d.cnt = o_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  assign conv_clk = o_q.conv;
  assign tone     = o_q.tone;
endmodule // lnbc_tone_osc

/* verilog/lnbc_top.sv */
// lnbc_top: dual channel supply control with serial register slave
`timescale 1ns/1ps
module lnbc_top (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic addr_strap_lo,
  input  wire logic addr_strap_hi,
  input  wire logic tone_mod_pin_a,
  input  wire logic tone_mod_pin_b,
  input  wire logic range_sel_pin_a,
  input  wire logic range_sel_pin_b,
  input  wire logic tone_det_in_a,
  input  wire logic tone_det_in_b,
  output logic      tone_det_n_a_o,
  output logic      tone_det_n_a_oe,
  output logic      tone_det_n_b_o,
  output logic      tone_det_n_b_oe,
  input  wire logic tx_indicate_a_in,
  output logic      tx_indicate_a_o,
  output logic      tx_indicate_a_oe,
  input  wire logic tx_indicate_b_in,
  output logic      tx_indicate_b_o,
  output logic      tx_indicate_b_oe,
  input  wire logic overcur_a,
  input  wire logic overcur_b,
  input  wire logic backcur_a,
  input  wire logic backcur_b,
  input  wire logic overtemp,
  output logic      fault_n_out_o,
  output logic      fault_n_out_oe,
  output logic      range_hi_a,
  output logic      range_hi_b,
  output logic      step_up_a,
  output logic      step_up_b,
  output logic      supply_tone_a,
  output logic      supply_tone_b,
  output logic      chan_enable_a,
  output logic      chan_enable_b,
  output logic      boost_conv_a,
  output logic      boost_conv_b,
  output logic      det_thresh_hi_a,
  output logic      det_thresh_hi_b
);
  typedef struct packed {
    lnbc_pkg::lnbc_i2c_st_t st;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic                   rw;
    logic                   ptr_ok;
    logic [1:0]             ptr;
    logic                   sda_oe;
    logic                   scl_p;
    logic                   sda_p;
    logic                   nack;
    logic                   strap_ok;
    logic [1:0]             strap;
    logic [1:0][7:0]        ctl;
    logic [1:0]             range_hi;
    logic [1:0]             step_up;
    logic [1:0]             conv_en;
    logic [1:0]             tone_o;
    logic [1:0]             det_oe;
    logic [1:0]             thr_hi;
    logic                   fault;
  } lnbc_state_t;

  lnbc_state_t q;
  lnbc_state_t n;

  logic       rst_q;
  logic [16:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] strap_s;
  logic [1:0] mod_s;
  logic [1:0] rsel_s;
  logic [1:0] det_s;
  logic [1:0] txi_s;
  logic [1:0] ovc_s;
  logic [1:0] bcf_s;
  logic       otf_s;
  logic       conv_clk;
  logic       tone;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;
  logic       all_off;
  logic [7:0] rb_cur;
  logic [7:0] rb_next;

  lnbc_sync #(.W(1)) u_rst_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (1'b1),
    .q     (rst_q)
  );

  lnbc_sync #(.W(17)) u_pin_sync (
    .mclk  (mclk),
    .rst_b (rst_q),
    .d     ({scl_in, sda_in, addr_strap_hi, addr_strap_lo,
             tone_mod_pin_b, tone_mod_pin_a, range_sel_pin_b, range_sel_pin_a,
             tone_det_in_b, tone_det_in_a, tx_indicate_b_in, tx_indicate_a_in,
             overcur_b, overcur_a, backcur_b, backcur_a, overtemp}),
    .q     (pin_s)
  );

  lnbc_tone_osc u_osc (
    .mclk     (mclk),
    .rst_b    (rst_q),
    .conv_clk (conv_clk),
    .tone     (tone)
  );

  assign {scl_s, sda_s, strap_s, mod_s, rsel_s, det_s, txi_s, ovc_s, bcf_s, otf_s} = pin_s;

  // bus conditions from synchronised levels
  assign start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
  assign stop_c  = scl_s && q.scl_p && !q.sda_p && sda_s;
  assign rise_c  = scl_s && !q.scl_p;
  assign fall_c  = !scl_s && q.scl_p;
  assign all_off = !q.ctl[0][lnbc_pkg::CB_EN] && !q.ctl[1][lnbc_pkg::CB_EN];

  function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic [1:0][7:0] ctl,
                                        input logic [1:0] oc, input logic [1:0] bc,
                                        input logic ot, input logic off, input logic [1:0] dt);
    logic [7:0] r;
    r = 8'h00;
    if (p == lnbc_pkg::REG_CTL_A) begin
      r = ctl[0];
    end else if (p == lnbc_pkg::REG_CTL_B) begin
      r = ctl[1];
    end else begin
      r[lnbc_pkg::SB_OVERCUR]  = oc[p[0]];
      r[lnbc_pkg::SB_BACKCUR]  = bc[p[0]];
      r[lnbc_pkg::SB_OVERTEMP] = ot;
      r[lnbc_pkg::SB_ALL_OFF]  = off;
      r[lnbc_pkg::SB_TONE_DET] = dt[p[0]];
    end
    return r;
  endfunction

  assign rb_cur  = rd_byte(q.ptr, q.ctl, ovc_s, bcf_s, otf_s, all_off, det_s);
  assign rb_next = rd_byte(q.ptr + 2'h1, q.ctl, ovc_s, bcf_s, otf_s, all_off, det_s);

  always_comb begin
    n       = q;
    n.scl_p = scl_s;
    n.sda_p = sda_s;
    // straps caught once, at the first start, when the synchroniser holds them
    if (!q.strap_ok && start_c) begin
      n.strap    = strap_s;
      n.strap_ok = 1'b1;
    end
    if (stop_c) begin
      n.st     = lnbc_pkg::I_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.st     = lnbc_pkg::I_ADDR;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
      n.ptr_ok = 1'b0;
    end else begin
      case (q.st)
        lnbc_pkg::I_ADDR: begin
          if (rise_c) begin
            n.sh  = {q.sh[6:0], sda_s};
            n.cnt = q.cnt + 4'h1;
          end else if (fall_c && q.cnt == lnbc_pkg::BITS_PER_BYTE) begin
            if (q.sh[7:1] == {lnbc_pkg::SLAVE_ADDR_BASE, q.strap}) begin
              n.st     = lnbc_pkg::I_AACK;
              n.sda_oe = 1'b1;
              n.rw     = q.sh[0];
            end else begin
              n.st = lnbc_pkg::I_IDLE;
            end
          end
        end
        lnbc_pkg::I_AACK: begin
          if (fall_c) begin
            n.cnt = q.rw ? 4'h1 : 4'h0;
            if (q.rw) begin
              n.st     = lnbc_pkg::I_RDAT;
              n.sh     = rb_cur;
              n.sda_oe = !rb_cur[7];
            end else begin
              n.st     = lnbc_pkg::I_WDAT;
              n.sda_oe = 1'b0;
            end
          end
        end
        lnbc_pkg::I_WDAT: begin
          if (rise_c) begin
            n.sh  = {q.sh[6:0], sda_s};
            n.cnt = q.cnt + 4'h1;
          end else if (fall_c && q.cnt == lnbc_pkg::BITS_PER_BYTE) begin
            n.st     = lnbc_pkg::I_WACK;
            n.sda_oe = 1'b1;
            if (!q.ptr_ok) begin
              n.ptr    = q.sh[1:0];
              n.ptr_ok = 1'b1;
            end else begin
              // status registers are read only
              if (!q.ptr[1]) begin
                n.ctl[q.ptr[0]] = q.sh;
              end
              n.ptr = q.ptr + 2'h1;
            end
          end
        end
        lnbc_pkg::I_WACK: begin
          if (fall_c) begin
            n.st     = lnbc_pkg::I_WDAT;
            n.sda_oe = 1'b0;
            n.cnt    = 4'h0;
          end
        end
        lnbc_pkg::I_RDAT: begin
          if (fall_c) begin
            if (q.cnt == lnbc_pkg::BITS_PER_BYTE) begin
              n.st     = lnbc_pkg::I_RACK;
              n.sda_oe = 1'b0;
            end else begin
              n.sda_oe = !q.sh[3'd7 - q.cnt[2:0]];
              n.cnt    = q.cnt + 4'h1;
            end
          end
        end
        lnbc_pkg::I_RACK: begin
          if (rise_c) begin
            n.nack = sda_s;
          end else if (fall_c) begin
            if (q.nack) begin
              n.st = lnbc_pkg::I_IDLE;
            end else begin
              n.st     = lnbc_pkg::I_RDAT;
              n.ptr    = q.ptr + 2'h1;
              n.sh     = rb_next;
              n.sda_oe = !rb_next[7];
              n.cnt    = 4'h1;
            end
          end
        end
        default: begin
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // per channel output control, two independent copies
    for (int i = 0; i < 2; i++) begin
      n.conv_en[i] = q.ctl[i][lnbc_pkg::CB_EN];
      if (!q.ctl[i][lnbc_pkg::CB_PIN_DIS]) begin
        n.range_hi[i] = rsel_s[i];
        n.step_up[i]  = rsel_s[i] ? q.ctl[i][lnbc_pkg::CB_HIGH_STEP] : q.ctl[i][lnbc_pkg::CB_LOW_STEP];
      end else begin
        n.range_hi[i] = q.ctl[i][lnbc_pkg::CB_HIGH_STEP];
        n.step_up[i]  = q.ctl[i][lnbc_pkg::CB_LOW_STEP];
      end
      if (!q.ctl[i][lnbc_pkg::CB_EN]) begin
        n.tone_o[i] = 1'b0;
      end else if (q.ctl[i][lnbc_pkg::CB_TONE_CONT]) begin
        n.tone_o[i] = tone;
      end else if (q.ctl[i][lnbc_pkg::CB_PASSTHRU]) begin
        n.tone_o[i] = mod_s[i];
      end else begin
        n.tone_o[i] = mod_s[i] && tone;
      end
      n.det_oe[i] = det_s[i];
      n.thr_hi[i] = q.ctl[i][lnbc_pkg::CB_THRESH] || txi_s[i];
    end
    n.fault = (|ovc_s) || (|bcf_s) || otf_s || all_off;
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sda_out          = 1'b0;
  assign sda_oe           = q.sda_oe;
  assign fault_n_out_o    = 1'b0;
  assign fault_n_out_oe   = q.fault;
  assign tone_det_n_a_o   = 1'b0;
  assign tone_det_n_a_oe  = q.det_oe[0];
  assign tone_det_n_b_o   = 1'b0;
  assign tone_det_n_b_oe  = q.det_oe[1];
  assign tx_indicate_a_o  = 1'b1;
  assign tx_indicate_a_oe = q.ctl[0][lnbc_pkg::CB_THRESH];
  assign tx_indicate_b_o  = 1'b1;
  assign tx_indicate_b_oe = q.ctl[1][lnbc_pkg::CB_THRESH];
  assign range_hi_a       = q.range_hi[0];
  assign range_hi_b       = q.range_hi[1];
  assign step_up_a        = q.step_up[0];
  assign step_up_b        = q.step_up[1];
  assign supply_tone_a    = q.tone_o[0];
  assign supply_tone_b    = q.tone_o[1];
  assign chan_enable_a    = q.conv_en[0];
  assign chan_enable_b    = q.conv_en[1];
  assign boost_conv_a     = conv_clk && q.conv_en[0];
  assign boost_conv_b     = conv_clk && q.conv_en[1];
  assign det_thresh_hi_a  = q.thr_hi[0];
  assign det_thresh_hi_b  = q.thr_hi[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_q);

  sequence s_addr_hit;
    q.st == lnbc_pkg::I_ADDR && fall_c && q.cnt == lnbc_pkg::BITS_PER_BYTE
      && q.sh[7:1] == {lnbc_pkg::SLAVE_ADDR_BASE, q.strap};
  endsequence
  sequence s_read_go;
    q.st == lnbc_pkg::I_AACK && fall_c && q.rw && !stop_c && !start_c;
  endsequence

  a_addr_ack: assert property (s_addr_hit ##0 !stop_c && !start_c |=> q.st == lnbc_pkg::I_AACK && sda_oe)
    else $error("address match not acknowledged");
  a_read_back: assert property (s_read_go |=> q.sh == $past(rb_cur) && sda_oe == !$past(rb_cur[7]))
    else $error("read byte not loaded from register");
  a_pin_low: assert property (!q.ctl[0][lnbc_pkg::CB_PIN_DIS] && !rsel_s[0]
    |=> !range_hi_a && step_up_a == $past(q.ctl[0][lnbc_pkg::CB_LOW_STEP]))
    else $error("pin low range wrong");
  a_pin_high: assert property (!q.ctl[1][lnbc_pkg::CB_PIN_DIS] && rsel_s[1]
    |=> range_hi_b && step_up_b == $past(q.ctl[1][lnbc_pkg::CB_HIGH_STEP]))
    else $error("pin high range wrong");
  a_pin_ignored: assert property (q.ctl[0][lnbc_pkg::CB_PIN_DIS] ##1 q.ctl[0][lnbc_pkg::CB_PIN_DIS] && $changed(rsel_s[0])
    |=> $stable(range_hi_a))
    else $error("range pin not ignored");
  a_tone_cont: assert property (q.ctl[0][lnbc_pkg::CB_EN] && q.ctl[0][lnbc_pkg::CB_TONE_CONT]
    |=> supply_tone_a == $past(tone))
    else $error("continuous tone missing");
  a_tone_pass: assert property (q.ctl[1][lnbc_pkg::CB_EN] && !q.ctl[1][lnbc_pkg::CB_TONE_CONT]
    && q.ctl[1][lnbc_pkg::CB_PASSTHRU] |=> supply_tone_b == $past(mod_s[1]))
    else $error("pass through tone wrong");
  a_tone_gate: assert property (!q.ctl[0][lnbc_pkg::CB_TONE_CONT] && !q.ctl[0][lnbc_pkg::CB_PASSTHRU]
    && !mod_s[0] |=> !supply_tone_a)
    else $error("tone not gated by envelope");
  a_chan_off: assert property (!q.ctl[1][lnbc_pkg::CB_EN] |=> !chan_enable_b && !boost_conv_b)
    else $error("disabled converter still runs");
  a_fault_off: assert property (all_off |=> fault_n_out_oe)
    else $error("fault not flagged with both channels off");
  a_fault_clear: assert property (!all_off && !otf_s && ovc_s == 2'b00 && bcf_s == 2'b00 |=> !fault_n_out_oe)
    else $error("fault held without cause");
  a_det_pull: assert property (det_s[0] |=> tone_det_n_a_oe)
    else $error("tone detect not signalled");
  a_thresh_sel: assert property (txi_s[1] || q.ctl[1][lnbc_pkg::CB_THRESH] |=> det_thresh_hi_b)
    else $error("threshold not high");
  a_reset_clear: assert property ($rose(rst_q) |-> q.ctl == '0 && !fault_n_out_oe ##1 fault_n_out_oe)
    else $error("control bits not cleared after reset");
endmodule // lnbc_top

/* sim/lnbc_host_model.sv */
// lnbc_host_model: serial bus host issuing register transfers
`timescale 1ns/1ps
module lnbc_host_model (
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic host_low;

  // open drain line with pull-up: released reads high
  assign sda = ~(host_low | sda_oe);

  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // also serves as repeated start from clock low
  task automatic start_cond();
    host_low <= 1'b0;
    tick(12);
    scl <= 1'b1;
    tick(12);
    host_low <= 1'b1;
    tick(12);
    scl <= 1'b0;
    tick(12);
  endtask

  task automatic stop_cond();
    host_low <= 1'b1;
    tick(12);
    scl <= 1'b1;
    tick(12);
    host_low <= 1'b0;
    tick(12);
  endtask

  // nine slots, msb first; tx[0] is the acknowledge slot
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      host_low <= ~tx[i];
      tick(13);
      scl <= 1'b1;
      tick(24);
      rx[i] = sda;
      tick(1);
      scl <= 1'b0;
      tick(12);
    end
  endtask

  // two data bytes per transfer; read sets pointer, then reads two
  task automatic access(input logic [6:0] adr, input logic [1:0] ptr, input logic rd,
                        input logic [15:0] wd, output logic [15:0] rdat, output logic ack);
    logic [8:0] r0, r1, r2, r3, r4;
    r2 = 9'h000;
    start_cond();
    byte_io({adr, 1'b0, 1'b1}, r0);
    byte_io({6'h00, ptr, 1'b1}, r1);
    if (rd) begin
      start_cond();
      byte_io({adr, 1'b1, 1'b1}, r2);
      byte_io(9'h1FE, r3);
      byte_io(9'h1FF, r4);
      r3[0] = 1'b0;
      r4[0] = 1'b0;
    end else begin
      byte_io({wd[15:8], 1'b1}, r3);
      byte_io({wd[7:0], 1'b1}, r4);
    end
    ack  = ~(r0[0] | r1[0] | r2[0] | r3[0] | r4[0]);
    rdat = {r3[8:1], r4[8:1]};
    stop_cond();
  endtask
endmodule // lnbc_host_model

/* sim/lnb_output_control_tb_top.sv */
// lnb_output_control_tb_top: self-checking bench for the dual supply control block
`timescale 1ns/1ps
module lnb_output_control_tb_top;
  localparam int WIN = 2 * lnbc_pkg::TONE_HALF_TICKS * lnbc_pkg::CONV_HALF_CYC;
  logic        mclk, rst_b, scl_in, sda_in, sda_oe;
  logic        addr_strap_lo, addr_strap_hi, tone_mod_pin_a, tone_mod_pin_b;
  logic        range_sel_pin_a, range_sel_pin_b, tone_det_in_a, tone_det_in_b;
  logic        tone_det_n_a_oe, tone_det_n_b_oe, txp_a, txp_b;
  logic        tx_indicate_a_in, tx_indicate_a_o, tx_indicate_a_oe;
  logic        tx_indicate_b_in, tx_indicate_b_o, tx_indicate_b_oe;
  logic        overcur_a, overcur_b, backcur_a, backcur_b, overtemp, fault_n_out_oe;
  logic        range_hi_a, range_hi_b, step_up_a, step_up_b, supply_tone_a, supply_tone_b;
  logic        chan_enable_a, chan_enable_b, boost_conv_a, boost_conv_b;
  logic        det_thresh_hi_a, det_thresh_hi_b;
  logic [14:0] drv;
  logic [12:0] obs;
  logic [3:0]  wav;
  logic [1:0]  strap;
  logic [7:0]  ctl [2];
  logic [31:0] rng;
  int          miscompares, tests_run;
  wire [3:0]   odv;

  assign {addr_strap_hi, addr_strap_lo, txp_b, txp_a, tone_det_in_b, tone_det_in_a} = drv[14:9];
  assign {range_sel_pin_b, range_sel_pin_a, tone_mod_pin_b, tone_mod_pin_a} = drv[8:5];
  assign {overtemp, backcur_b, backcur_a, overcur_b, overcur_a} = drv[4:0];
  // pin level: device driver wins, else external level
  assign tx_indicate_a_in = tx_indicate_a_oe ? tx_indicate_a_o : txp_a;
  assign tx_indicate_b_in = tx_indicate_b_oe ? tx_indicate_b_o : txp_b;
  assign obs = {range_hi_b, step_up_b, chan_enable_b, det_thresh_hi_b, tone_det_n_b_oe, tx_indicate_b_oe,
                range_hi_a, step_up_a, chan_enable_a, det_thresh_hi_a, tone_det_n_a_oe, tx_indicate_a_oe,
                fault_n_out_oe};
  assign wav = {supply_tone_b, supply_tone_a, boost_conv_b, boost_conv_a};

  lnbc_top DUT (
    .mclk, .rst_b, .scl_in, .sda_in, .sda_out(odv[3]), .sda_oe, .addr_strap_lo, .addr_strap_hi,
    .tone_mod_pin_a, .tone_mod_pin_b, .range_sel_pin_a, .range_sel_pin_b, .tone_det_in_a,
    .tone_det_in_b, .tone_det_n_a_o(odv[1]), .tone_det_n_a_oe, .tone_det_n_b_o(odv[0]), .tone_det_n_b_oe,
    .tx_indicate_a_in, .tx_indicate_a_o, .tx_indicate_a_oe, .tx_indicate_b_in, .tx_indicate_b_o,
    .tx_indicate_b_oe, .overcur_a, .overcur_b, .backcur_a, .backcur_b, .overtemp,
    .fault_n_out_o(odv[2]), .fault_n_out_oe, .range_hi_a, .range_hi_b, .step_up_a, .step_up_b,
    .supply_tone_a, .supply_tone_b, .chan_enable_a, .chan_enable_b, .boost_conv_a,
    .boost_conv_b, .det_thresh_hi_a, .det_thresh_hi_b
  );

  lnbc_host_model host (.mclk, .sda_oe, .scl(scl_in), .sda(sda_in));

  always #25 mclk = ~mclk;

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [5:0] chan_exp(input logic [7:0] c, input logic rs, dt, tp);
    logic rh;
    rh = c[3] ? c[2] : rs;
    return {rh, (c[3] | !rs) ? c[1] : c[2], c[0], c[6] | tp, dt, c[6]};
  endfunction

  function automatic logic [7:0] regv(input logic [1:0] i);
    logic off;
    off = ~ctl[0][0] & ~ctl[1][0];
    case (i)
      2'h0: return ctl[0];
      2'h1: return ctl[1];
      2'h2: return {3'h0, tone_det_in_a, off, overtemp, backcur_a, overcur_a};
      default: return {3'h0, tone_det_in_b, off, overtemp, backcur_b, overcur_b};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    strap = s;
    rst_b <= 1'b0;
    drv   <= {s, 13'h0000};
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    ctl[0] = 8'h00;
    ctl[1] = 8'h00;
    repeat (12) @(posedge mclk);
  endtask

  task automatic check_all();
    logic [15:0] q;
    logic        ack, act, m;
    logic [1:0]  p;
    logic [7:0]  c;
    logic [3:0]  lv;
    int          cnt [4];
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check(obs, {chan_exp(ctl[1], range_sel_pin_b, tone_det_in_b, txp_b),
                chan_exp(ctl[0], range_sel_pin_a, tone_det_in_a, txp_a),
                |drv[4:0] | (~ctl[0][0] & ~ctl[1][0])});
    check({odv, tx_indicate_b_o, tx_indicate_a_o}, 6'h03);
    lv  = wav;
    cnt = '{default: 0};
    repeat (WIN) begin
      @(negedge mclk);
      for (int k = 0; k < 4; k++)
        cnt[k] += int'(wav[k] != lv[k]);
      lv = wav;
    end
    for (int ch = 0; ch < 2; ch++) begin
      c   = ctl[ch];
      m   = ch ? tone_mod_pin_b : tone_mod_pin_a;
      act = c[0] & (c[4] | (!c[5] & m));
      check(cnt[ch], c[0] ? WIN / lnbc_pkg::CONV_HALF_CYC : 0);
      check(cnt[ch+2], act ? 2 : 0);
      if (!act)
        check(wav[ch+2], c[0] & c[5] & m);
    end
    p = 2'(xs());
    @(posedge mclk);
    host.access({lnbc_pkg::SLAVE_ADDR_BASE, strap}, p, 1'b1, 16'h0000, q, ack);
    check(ack, 1'b1);
    check(q, {regv(p), regv(2'(p + 2'h1))});
  endtask

  initial begin
    logic [15:0] q, w;
    logic        ack;
    logic [1:0]  p;
    mclk        = 1'b0;
    rst_b       = 1'b0;
    drv         = '0;
    rng         = 32'hF1E0F2E5;
    miscompares = 0;
    tests_run   = 0;
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      check_all();
      @(posedge mclk);
      host.access({lnbc_pkg::SLAVE_ADDR_BASE, strap ^ 2'h1}, 2'h0, 1'b0, 16'h0101, q, ack);
      check(ack, 1'b0);
      @(posedge mclk);
      host.access({lnbc_pkg::SLAVE_ADDR_BASE, strap}, 2'h0, 1'b0, 16'h0000, q, ack);
      check(ack, 1'b1);
      check_all();
    end
    for (int i = 0; i < 10; i++) begin
      p = 2'(xs());
      w = 16'(xs()) & 16'h7F7F;
      // odd rounds: continuous tone off while the modulation pins hold random levels
      if (i[0])
        w = w & 16'h6F6F;
      drv[12:0] <= {8'(xs()), 5'(xs() & xs())};
      @(posedge mclk);
      host.access({lnbc_pkg::SLAVE_ADDR_BASE, strap}, p, 1'b0, w, q, ack);
      check(ack, 1'b1);
      // pointer wraps in two bits; status places ignore writes
      for (int k = 0; k < 2; k++)
        if (2'(p + 2'(k)) < 2'h2)
          ctl[2'(p + 2'(k))] = k ? w[7:0] : w[15:8];
      check_all();
    end
    results();
  end
endmodule // lnb_output_control_tb_top
